//--- hdl/lmfc_pkg.sv
// Purpose: constants and types of the multiplexed lcd frame controller
// Assumes: core_clk is the mcu internal clock, data space is 8-bit
// Notes: divisor tables live here as functions of the select codes
//
// Overview of operation
// - The duty field picks 1, 2, 3 or 4 active backplanes, code 00 meaning four.
// - The base frame rate is the reference divided by 512, 386, 256, 192, 128, 96 or 64.
// - Each backplane holds one base period, so the frame rate is base over backplanes.
// - The source field turns the display off (000), takes the aux osc (001) or the mcu clock.
// - Source codes 011 to 110 divide the mcu clock by 32, 64, 128 and 256.
// - A new source or display setting is taken only when the current frame completes, or at once while the scanner is idle.
// - Stop without the aux source in effect switches off and grounds every segment and backplane output.
// - A failed oscillator grounds every segment and backplane output.
// - The bias divider is enabled only while the display driver runs.
// - Third bias levels serve 1/1, 1/3 and 1/4 duty; 1/2 duty is flagged for the board.
// - A set display bit turns its element on, a clear bit keeps it off.
// - Display storage spans E0 to F7, six bytes per backplane, segments rising with bits.
// - Display storage is not cleared by reset.
// - Bytes of unused backplanes are plain storage and never reach the outputs.
// - The control register holds duty in 7-6, source in 5-3 and frame rate in 2-0.
package lmfc_pkg;
	localparam logic [7:0] ADDR_CTRL = 8'hDC;
	localparam logic [7:0] ADDR_RAM_FIRST = 8'hE0;
	localparam logic [7:0] ADDR_RAM_LAST = 8'hF7;
	localparam int RAM_BYTES = 24;
	localparam int BYTES_PER_COM = 6;
	localparam int NUM_COM = 4;
	localparam int SEG_BITS = 48;
	localparam int SEG_UNUSED = 3;
	localparam int DUTY_LSB = 6;
	localparam int SRC_LSB = 3;
	localparam int RATE_LSB = 0;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [1:0] DUTY_4 = 2'h0;
	localparam logic [1:0] DUTY_1 = 2'h1;
	localparam logic [1:0] DUTY_2 = 2'h2;
	localparam logic [1:0] DUTY_3 = 2'h3;
	localparam logic [2:0] SRC_OFF = 3'h0;
	localparam logic [2:0] SRC_AUX = 3'h1;
	localparam logic [2:0] SRC_RSV_A = 3'h2;
	localparam logic [2:0] SRC_RSV_B = 3'h7;
	localparam logic [2:0] RATE_RSV = 3'h7;
	localparam int PRE_W = 9;
	localparam int BASE_W = 10;

	typedef struct packed {
		logic [1:0] duty;
		logic [2:0] src;
		logic [2:0] rate;
	} lmfc_cfg_t;

	typedef enum logic [1:0] {
		ST_OFF = 2'b01,
		ST_SCAN = 2'b10
	} lmfc_state_t;

	// mcu clock divide per source code, zero where no division applies
	function automatic logic [PRE_W-1:0] src_div(input logic [2:0] s);
		unique case (s)
			3'h3: src_div = 9'h020;
			3'h4: src_div = 9'h040;
			3'h5: src_div = 9'h080;
			3'h6: src_div = 9'h100;
			default: src_div = 9'h000;
		endcase
	endfunction

	// reference ticks per base period (386 kept as printed)
	function automatic logic [BASE_W-1:0] base_div(input logic [2:0] r);
		unique case (r)
			3'h0: base_div = 10'h200;
			3'h1: base_div = 10'h182;
			3'h2: base_div = 10'h100;
			3'h3: base_div = 10'h0C0;
			3'h4: base_div = 10'h080;
			3'h5: base_div = 10'h060;
			3'h6: base_div = 10'h040;
			default: base_div = 10'h000;
		endcase
	endfunction

	// index of the last active backplane
	function automatic logic [1:0] last_com(input logic [1:0] d);
		unique case (d)
			DUTY_4: last_com = 2'h3;
			DUTY_1: last_com = 2'h0;
			DUTY_2: last_com = 2'h1;
			default: last_com = 2'h2;
		endcase
	endfunction
endpackage

//--- hdl/lmfc_top.sv
// Purpose: scans display storage onto segment and backplane drive lines
// Assumes: all inputs synchronous to core_clk; aux osc arrives as a sampled level
// Notes: analog levels are outside; outputs are logic drive codes per line
`timescale 1ns/1ns
module lmfc_top
	import lmfc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	output logic [7:0] bus_rdata,
	input wire logic aux_low_speed_osc,
	input wire logic stop_mode,
	input wire logic osc_fail,
	output logic [SEG_BITS-1:0] seg_on,
	output logic [NUM_COM-1:0] backplane_sel,
	output logic frame_phase,
	output logic display_on,
	output logic bias_div_en,
	output logic half_bias_mode
);

	////////////////////////////////////////////////////////////////////////////
	// declarations

	lmfc_cfg_t ctrl;
	lmfc_cfg_t act;
	lmfc_state_t state;
	logic [7:0] ram [RAM_BYTES];
	logic aux_q;
	logic aux_rise;
	logic [PRE_W-1:0] pre_cnt;
	logic [PRE_W-1:0] pre_div;
	logic [BASE_W-1:0] base_cnt;
	logic [BASE_W-1:0] base_len;
	logic [1:0] com_idx;
	logic ref_tick;
	logic base_end;
	logic frame_end;
	logic src_is_mcu;
	logic cfg_valid;
	logic run_ok;
	logic stop_kill;
	logic ctrl_hit;
	logic ram_hit;
	logic [4:0] ram_wsel;
	logic [4:0] row_base;
	logic [SEG_BITS-1:0] row_bits;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	assign ctrl_hit = (bus_addr == ADDR_CTRL);
	assign ram_hit = (bus_addr >= ADDR_RAM_FIRST) && (bus_addr <= ADDR_RAM_LAST);
	assign ram_wsel = 5'(bus_addr - ADDR_RAM_FIRST);

	// control register, all fields read/write
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			ctrl <= lmfc_cfg_t'(CTRL_RESET);
		else if (bus_wr && ctrl_hit)
			ctrl <= lmfc_cfg_t'(bus_wdata);
	end

	// display storage has no reset so contents stay arbitrary until written
	always_ff @(posedge core_clk)
	begin
		if (bus_wr && ram_hit)
			ram[ram_wsel] <= bus_wdata;
	end

	// registered read data; unmapped addresses read as zero
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			bus_rdata <= 8'h00;
		else if (bus_rd && ctrl_hit)
			bus_rdata <= ctrl;
		else if (bus_rd && ram_hit)
			bus_rdata <= ram[ram_wsel];
		else if (bus_rd)
			bus_rdata <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////////////
	// run conditions of the applied setting

	assign src_is_mcu = (src_div(act.src) != 9'h000);
	assign cfg_valid = (act.src != SRC_OFF) && (act.src != SRC_RSV_A)
		&& (act.src != SRC_RSV_B) && (act.rate != RATE_RSV);
	// stop kills the mcu reference; only the aux source survives it
	assign run_ok = cfg_valid && !osc_fail && !stop_kill
		&& !(stop_mode && (act.src != SRC_AUX));

	// a stop that finds the mcu source applied keeps the driver off until wake-up,
	// even if an aux setting was pending and lands once the scanner is idle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			stop_kill <= 1'b0;
		else if (!stop_mode)
			stop_kill <= 1'b0;
		else if (state == ST_SCAN && act.src != SRC_AUX)
			stop_kill <= 1'b1;
	end

	// state of the scanner
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state <= ST_OFF;
		else
		begin
			unique case (state)
				ST_OFF: if (run_ok) state <= ST_SCAN;
				ST_SCAN: if (!run_ok) state <= ST_OFF;
			endcase
		end
	end

	// a new setting lands only between frames, or at once while idle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			act <= lmfc_cfg_t'(CTRL_RESET);
		else if (state == ST_OFF || frame_end)
			act <= ctrl;
	end

	////////////////////////////////////////////////////////////////////////////
	// reference clock: mcu prescaler or aux rising edge

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			aux_q <= 1'b0;
		else
			aux_q <= aux_low_speed_osc;
	end

	assign aux_rise = aux_low_speed_osc && !aux_q;
	assign pre_div = src_div(act.src);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			pre_cnt <= '0;
		else if (state != ST_SCAN || !src_is_mcu || pre_cnt == pre_div - 9'h001)
			pre_cnt <= '0;
		else
			pre_cnt <= pre_cnt + 9'h001;
	end

	assign ref_tick = (state == ST_SCAN) && (src_is_mcu
		? (pre_cnt == pre_div - 9'h001)
		: aux_rise);

	////////////////////////////////////////////////////////////////////////////
	// base period and backplane stepping

	assign base_len = base_div(act.rate);
	assign base_end = ref_tick && (base_cnt == base_len - 10'h001);
	assign frame_end = base_end && (com_idx == last_com(act.duty));

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			base_cnt <= '0;
		else if (state != ST_SCAN || base_end)
			base_cnt <= '0;
		else if (ref_tick)
			base_cnt <= base_cnt + 10'h001;
	end

	// one base period per backplane, wrapping at the last active one
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			com_idx <= 2'h0;
		else if (state != ST_SCAN || frame_end)
			com_idx <= 2'h0;
		else if (base_end)
			com_idx <= com_idx + 2'h1;
	end

	// polarity flips every frame so the glass sees no net dc
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			frame_phase <= 1'b0;
		else if (state != ST_SCAN)
			frame_phase <= 1'b0;
		else if (frame_end)
			frame_phase <= !frame_phase;
	end

	////////////////////////////////////////////////////////////////////////////
	// row fetch: only the driven backplane's six bytes are ever read

	assign row_base = 5'(com_idx * BYTES_PER_COM);

	for (genvar k = 0; k < BYTES_PER_COM; k++)
	begin : g_row
		assign row_bits[8*k +: 8] = ram[row_base + 5'(k)];
	end

	// segment drive, low bits of the first byte never reach a pin
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			seg_on <= '0;
		else if (state == ST_SCAN && run_ok)
			seg_on <= {row_bits[SEG_BITS-1:SEG_UNUSED], SEG_UNUSED'(0)};
		else
			seg_on <= '0;
	end

	// backplane drive, one-hot of the current common
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			backplane_sel <= '0;
		else if (state == ST_SCAN && run_ok)
			backplane_sel <= 4'h1 << com_idx;
		else
			backplane_sel <= '0;
	end

	////////////////////////////////////////////////////////////////////////////
	// driver power and bias control

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			display_on <= 1'b0;
			bias_div_en <= 1'b0;
			half_bias_mode <= 1'b0;
		end
		else
		begin
			display_on <= (state == ST_SCAN) && run_ok;
			bias_div_en <= (state == ST_SCAN) && run_ok;
			half_bias_mode <= (act.duty == DUTY_2);
		end
	end

endmodule

//--- verification/lmfc_glass.sv
// Purpose: passive glass, keeps the last pattern seen per backplane
// Assumes: grounded lines leave the picture as it was
// Notes: drives nothing back into the block
`timescale 1ns/1ns
module lmfc_glass
	import lmfc_pkg::*;
(
	input wire logic core_clk,
	input wire logic [SEG_BITS-1:0] seg_on,
	input wire logic [NUM_COM-1:0] backplane_sel,
	output logic [SEG_BITS-1:0] pix [NUM_COM]
);
	// an element shows what its plane carried while driven
	always_ff @(posedge core_clk)
		for (int c = 0; c < NUM_COM; c++)
			if (backplane_sel[c])
				pix[c] <= seg_on;
endmodule

//--- verification/lmfc_top_chk.sv
// Purpose: port checker of lmfc_top
// Assumes: reference ticks at most every second cycle
// Notes: ctrl_m mirrors control writes
`timescale 1ns/1ns
module lmfc_top_chk
	import lmfc_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [7:0] bus_addr,
	input wire logic bus_wr,
	input wire logic bus_rd,
	input wire logic [7:0] bus_wdata,
	input wire logic [7:0] bus_rdata,
	input wire logic osc_fail,
	input wire logic [SEG_BITS-1:0] seg_on,
	input wire logic [NUM_COM-1:0] backplane_sel,
	input wire logic frame_phase,
	input wire logic display_on,
	input wire logic bias_div_en
);
	logic [7:0] ctrl_m;
	default clocking @(posedge core_clk);
	endclocking
	default disable iff (!rstn);
	////////////////////////////////////////////////////////////////////////////////
	// mirror of the control register, reads must match it
	always_ff @(posedge core_clk or negedge rstn)
		if (!rstn)
			ctrl_m <= CTRL_RESET;
		else if (bus_wr && bus_addr == ADDR_CTRL)
			ctrl_m <= bus_wdata;
	a_bias_tracks: assert property (bias_div_en == display_on)
		else $error("bias enable differs");
	a_fail_ground: assert property (osc_fail |=> !display_on && seg_on == '0)
		else $error("not grounded on fail");
	a_off_ground: assert property (!display_on |-> seg_on == '0 && backplane_sel == '0)
		else $error("lines live while off");
	a_one_plane: assert property (display_on |-> $onehot(backplane_sel) && seg_on[2:0] == 3'h0)
		else $error("bad plane select");
	a_slot_hold: assert property (display_on && $changed(backplane_sel) |=>
		(!display_on || $stable(backplane_sel)) [*8])
		else $error("slot too short");
	a_scan_step: assert property (display_on && $past(display_on) && $changed(backplane_sel)
		|-> backplane_sel == 4'h1 || backplane_sel == $past(backplane_sel) << 1)
		else $error("plane order");
	// backplane_sel is one register behind the scan index, so plane one shows a cycle later
	a_wrap_phase: assert property (display_on && $past(display_on) && $changed(frame_phase)
		|=> !display_on || backplane_sel == 4'h1)
		else $error("frame end off plane one");
	a_ctrl_read: assert property (bus_rd && !bus_wr && bus_addr == ADDR_CTRL
		|=> bus_rdata == $past(ctrl_m))
		else $error("control readback");
endmodule
bind lmfc_top lmfc_top_chk lmfc_top_chk_inst (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd,
	.bus_wdata, .bus_rdata, .osc_fail, .seg_on, .backplane_sel, .frame_phase, .display_on,
	.bias_div_en);

//--- verification/lmfc_top_test.sv
// Purpose: self-checking bench of lmfc_top
// Assumes: aux osc toggles every cycle, so a tick is two cycles
// Notes: frame lengths are measured between phase toggles
`timescale 1ns/1ns
module lmfc_top_test
	import lmfc_pkg::*;
;
	logic core_clk = 0, rstn = 0, bus_wr = 0, bus_rd = 0;
	logic aux_low_speed_osc = 0, stop_mode = 0, osc_fail = 0;
	logic [7:0] bus_addr = 8'h00, bus_wdata = 8'h00, bus_rdata;
	logic [SEG_BITS-1:0] seg_on;
	logic [SEG_BITS-1:0] pix [NUM_COM];
	logic [NUM_COM-1:0] backplane_sel;
	logic frame_phase, display_on, bias_div_en, half_bias_mode;
	int num_errors = 0, samples_checked = 0;
	lmfc_top lmfc_top_inst (.core_clk, .rstn, .bus_addr, .bus_wr, .bus_rd, .bus_wdata,
		.bus_rdata, .aux_low_speed_osc, .stop_mode, .osc_fail, .seg_on, .backplane_sel,
		.frame_phase, .display_on, .bias_div_en, .half_bias_mode);
	lmfc_glass lmfc_glass_inst (.core_clk, .seg_on, .backplane_sel, .pix);
	////////////////////////////////////////////////////////////////////////////////
	// clock and a fast aux osc to keep frames short
	always #50 core_clk = ~core_clk;
	always @(posedge core_clk) aux_low_speed_osc <= ~aux_low_speed_osc;
	task automatic chk(string what, logic [SEG_BITS-1:0] exp, logic [SEG_BITS-1:0] got);
		samples_checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge core_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge core_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] e);
		@(posedge core_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge core_clk);
		bus_rd <= 1'b0;
		@(negedge core_clk);
		chk("rdata", 48'(e), 48'(bus_rdata));
	endtask
	// cycles to the next phase toggle, bounded
	task automatic tog(output int n);
		logic p;
		n = 0;
		p = frame_phase;
		while (frame_phase === p && n < 40000)
		begin
			@(negedge core_clk);
			n++;
		end
		chk("toggle", 48'h1, 48'(frame_phase !== p));
	endtask
	task automatic end_sim();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic t_regs();
		rd(ADDR_CTRL, CTRL_RESET);
		wr(ADDR_CTRL, 8'hC9);
		rd(ADDR_CTRL, 8'hC9);
		rd(8'h10, 8'h00);
		wr(8'hF7, 8'h5A);
		rd(8'hF7, 8'h5A);
		$display("regs done");
	endtask
	task automatic t_scan();
		int n;
		logic [SEG_BITS-1:0] e;
		logic [3:0] seen;
		logic [1:0] dl [4] = '{2'h1, 2'h2, 2'h3, 2'h0};
		for (int c = 0; c < 24; c++)
			wr(8'(ADDR_RAM_FIRST + c), 8'((c / 6) * 64 + (c % 6) * 8 + 7));
		foreach (dl[i])
		begin
			wr(ADDR_CTRL, {dl[i], SRC_AUX, 3'h6});
			tog(n);
			seen = 4'h0;
			repeat (1100)
			begin
				@(negedge core_clk);
				seen |= backplane_sel;
			end
			chk("planes", 48'((5'h2 << i) - 1), 48'(seen));
			chk("half", 48'(dl[i] == DUTY_2), 48'(half_bias_mode));
			for (int c = 0; c <= i; c++)
			begin
				for (int k = 0; k < 6; k++)
					e[k*8 +: 8] = 8'(c * 64 + k * 8 + 7);
				chk("glass", e & ~48'h7, pix[c]);
			end
		end
		wr(8'hE8, 8'h00);
		repeat (600) @(negedge core_clk);
		chk("update", 48'h0, 48'(pix[1][23:16]));
		$display("scan done");
	endtask
	task automatic t_stop();
		int n;
		logic [7:0] bad [4] = '{8'h40, 8'h50, 8'h7E, 8'h4F};
		wr(ADDR_CTRL, 8'h5E);
		tog(n);
		tog(n);
		// aux requested but not yet applied: stop must still shut the driver
		wr(ADDR_CTRL, 8'h4E);
		@(posedge core_clk);
		stop_mode <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk("stop", 48'h0, seg_on | 48'({backplane_sel, display_on}));
		repeat (300) @(negedge core_clk);
		chk("stop held", 48'h0, 48'({display_on, bias_div_en}));
		@(posedge core_clk);
		stop_mode <= 1'b0;
		wr(ADDR_CTRL, 8'h4E);
		tog(n);
		tog(n);
		@(posedge core_clk);
		stop_mode <= 1'b1;
		repeat (200) @(negedge core_clk);
		chk("stop aux", 48'h1, 48'(display_on));
		@(posedge core_clk);
		stop_mode <= 1'b0;
		osc_fail <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk("fail", 48'h0, seg_on | 48'({backplane_sel, display_on}));
		@(posedge core_clk);
		osc_fail <= 1'b0;
		foreach (bad[i])
		begin
			wr(ADDR_CTRL, 8'h4E);
			repeat (300) @(negedge core_clk);
			chk("on", 48'h1, 48'(display_on));
			wr(ADDR_CTRL, bad[i]);
			repeat (600) @(negedge core_clk);
			chk("off", 48'h0, 48'({display_on, bias_div_en}));
		end
		$display("stop done");
	endtask
	task automatic t_rate();
		int n;
		logic [7:0] cf [12] = '{8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h0E,
			8'h5E, 8'h66, 8'h6E, 8'h76};
		int per [12] = '{1024, 772, 512, 384, 256, 192, 128, 512, 2048, 4096, 8192, 16384};
		wr(ADDR_CTRL, 8'h4E);
		tog(n);
		tog(n);
		wr(ADDR_CTRL, cf[0]);
		tog(n);
		chk("old frame", 48'd127, 48'(n));
		foreach (cf[i])
		begin
			wr(ADDR_CTRL, cf[i]);
			tog(n);
			tog(n);
			chk("frame", 48'(per[i]), 48'(n));
		end
		$display("rate done");
	endtask
	// reset, then the scenarios in turn
	initial
	begin
		repeat (12) @(posedge core_clk);
		rstn <= 1'b1;
		t_regs();
		t_scan();
		t_stop();
		t_rate();
		end_sim();
	end
	// the scenarios take about 70k cycles; a hang is cut off before 100k
	initial
	begin
		repeat (90000) @(posedge core_clk);
		num_errors++;
		end_sim();
	end
endmodule
